// >>> csb_bank.sv
// setpoint command bank: top level with setpoints, charge gating, loop choice and gate drive
// Overview of operation
// RULE_01: command 0x15 word loads voltage setpoint
// RULE_02: command 0x14 word loads current setpoint
// RULE_03: command 0x3f word loads adapter limit
// RULE_04: voltage field bits 4..14, 16 mV steps
// RULE_05: voltage bits 0..3 and 15 ignored
// RULE_06: voltage below 1.024 V stops charging
// RULE_07: reset clears setpoints; both writes re-enable
// RULE_08: both gate drives low while charging off; the drives drop one cycle after charge_enable falls
// RULE_09: current field bits 7..12, 128 mA steps
// RULE_10: current bits 0..6 and 13..15 ignored
// RULE_11: zero current setpoint terminates charging
// RULE_12: low battery forces 128 mA, setpoint kept
// RULE_13: adapter limit 256 mA steps, up to 11 A; the code has no upper clamp, field 0x3f gives 16.128 A
// RULE_14: limit settings under one step give 256 mA
// RULE_15: adapter limit is 256 mA after reset
// RULE_16: current loop below setpoint, voltage loop after
// RULE_17: adapter overcurrent loop takes control, cuts charge
// RULE_18: 175 s without setpoint write stops charging
// RULE_19: adapter field bits 7..12, rest ignored
// RULE_20: other command codes change no setpoint
`timescale 1ns/10ps
`default_nettype none
`include "csb_cfg.svh"

module csb_bank
  import csb_pkg::*;
#(
  parameter logic [6:0]      SLAVE_ADDR     = 7'h2a,  // arbitrary value
  parameter longint unsigned TIMEOUT_CYCLES = `CSB_TIMEOUT_CYCLES,
  parameter int              TIMEOUT_W      = 33
) (
  input  wire logic   sys_clk,
  input  wire logic   reset,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe,
  input  wire logic   battery_low,
  input  wire logic   battery_below_volts,
  input  wire logic   battery_below_amps,
  input  wire logic   adapter_over_limit,
  output logic [10:0] volt_setting_bits,
  output logic [5:0]  amp_setting_bits,
  output logic [5:0]  adapter_setting_bits,
  output logic        charge_enable,
  output csb_loop_t   active_loop,
  output logic        high_side_gate_drive,
  output logic        low_side_gate_drive
);

  csb_wr_if wr ();

  // ----------------------------------------------------------------
  // command decode; unknown codes select nothing
  // ----------------------------------------------------------------
  wire volt_wr = wr.wr_stb && (wr.cmd == `CSB_CMD_VOLTS);    // RULE_01 RULE_20
  wire amp_wr  = wr.wr_stb && (wr.cmd == `CSB_CMD_AMPS);     // RULE_02 RULE_20
  wire adp_wr  = wr.wr_stb && (wr.cmd == `CSB_CMD_ADAPTER);  // RULE_03 RULE_20

  logic [10:0] battery_target_volts;
  logic [5:0]  battery_target_amps;
  logic [5:0]  adapter_limit_amps;
  logic        volts_written;
  logic        amps_written;
  logic [1:0]  low_sync;
  logic [1:0]  bv_sync;
  logic [1:0]  ba_sync;
  logic [1:0]  ad_sync;
  logic [7:0]  pwm_cnt;
  logic [7:0]  duty;
  logic        expired;

  // ----------------------------------------------------------------
  // serial receiver and watchdog
  // ----------------------------------------------------------------
  csb_smbus_rx #(
    .SLAVE_ADDR (SLAVE_ADDR)
  ) u_rx (
    .sys_clk (sys_clk),
    .reset   (reset),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_oe  (sda_oe),
    .wr      (wr.rx)
  );

  csb_timeout #(
    .TW     (TIMEOUT_W),
    .CYCLES (TIMEOUT_CYCLES)
  ) u_timeout (
    .sys_clk (sys_clk),
    .reset   (reset),
    .kick    (volt_wr | amp_wr),
    .expired (expired)
  );

  // ----------------------------------------------------------------
  // field extraction and clamp
  // ----------------------------------------------------------------

  // field extraction: unused bits never reach the stored value
  wire [10:0] volt_field = wr.data[`CSB_VOLT_MSB:`CSB_VOLT_LSB];  // RULE_04 RULE_05
  wire [5:0]  amp_field  = wr.data[`CSB_AMP_MSB:`CSB_AMP_LSB];    // RULE_09 RULE_10
  wire [5:0]  adp_field  = wr.data[`CSB_ADP_MSB:`CSB_ADP_LSB];    // RULE_13 RULE_19

  // limits below one step resolve to one step
  wire [5:0] adp_clamped = (adp_field < `CSB_ADP_MIN) ? `CSB_ADP_MIN : adp_field;  // RULE_14

  // ----------------------------------------------------------------
  // setpoint registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      battery_target_volts <= `CSB_VOLT_RESET;   // RULE_07
      battery_target_amps  <= `CSB_AMP_RESET;    // RULE_07
      adapter_limit_amps   <= `CSB_ADP_RESET;    // RULE_15
    end else begin
      if (volt_wr)
        battery_target_volts <= volt_field;      // RULE_01
      if (amp_wr)
        battery_target_amps <= amp_field;        // RULE_02
      if (adp_wr)
        adapter_limit_amps <= adp_clamped;       // RULE_03
    end
  end

  // ----------------------------------------------------------------
  // written flags: a write in the expiry cycle still counts
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      volts_written <= 1'b0;                     // RULE_07
      amps_written  <= 1'b0;
    end else begin
      volts_written <= volt_wr | (volts_written & ~expired);  // RULE_18
      amps_written  <= amp_wr | (amps_written & ~expired);    // RULE_18
    end
  end

  // ----------------------------------------------------------------
  // comparator inputs come from the analog side, so two stages each
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      low_sync <= 2'b00;  // idle level, so no false foldback right after reset
      bv_sync  <= 2'b00;
      ba_sync  <= 2'b00;
      ad_sync  <= 2'b00;
    end else begin
      low_sync <= {low_sync[0], battery_low};
      bv_sync  <= {bv_sync[0], battery_below_volts};
      ba_sync  <= {ba_sync[0], battery_below_amps};
      ad_sync  <= {ad_sync[0], adapter_over_limit};
    end
  end

  // ----------------------------------------------------------------
  // charge gate and effective setpoints
  // ----------------------------------------------------------------
  wire volts_ok   = battery_target_volts >= `CSB_VOLT_MIN_CODE;  // RULE_06
  wire amps_ok    = battery_target_amps != 6'h00;                // RULE_11
  wire next_en    = volts_written & amps_written & volts_ok & amps_ok;  // RULE_07 RULE_18
  // foldback replaces only the driven value, the register is untouched
  wire [5:0] next_amp_bits = low_sync[1] ? `CSB_AMP_FOLDBACK : battery_target_amps;  // RULE_12

  // ----------------------------------------------------------------
  // loop choice: adapter overcurrent first, then current, then voltage
  // ----------------------------------------------------------------
  csb_loop_t next_loop;
  assign next_loop = !charge_enable ? CSB_LOOP_OFF :
                     ad_sync[1]     ? CSB_LOOP_ADAPTER :   // RULE_17
                     bv_sync[1]     ? CSB_LOOP_AMPS :      // RULE_16
                                      CSB_LOOP_VOLTS;      // RULE_16

  // duty steering: each loop nudges the on-time by one step
  wire duty_up   = (active_loop == CSB_LOOP_AMPS) && ba_sync[1] && (duty != 8'hfe);
  wire duty_down = (active_loop == CSB_LOOP_ADAPTER) ||                         // RULE_17
                   (active_loop == CSB_LOOP_VOLTS && !bv_sync[1]) ||            // RULE_16
                   (active_loop == CSB_LOOP_AMPS && !ba_sync[1]);
  wire [7:0] next_duty = !charge_enable        ? 8'h00 :
                         (pwm_cnt != 8'h00)    ? duty :
                         duty_up               ? duty + 8'h01 :
                         (duty_down && duty != 8'h00) ? duty - 8'h01 :
                                                 duty;

  // ----------------------------------------------------------------
  // status outputs, registered
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      charge_enable        <= 1'b0;
      active_loop          <= CSB_LOOP_OFF;
      volt_setting_bits    <= `CSB_VOLT_RESET;
      amp_setting_bits     <= `CSB_AMP_RESET;
      adapter_setting_bits <= `CSB_ADP_RESET;
      sda_out              <= 1'b0;
    end else begin
      charge_enable        <= next_en;
      active_loop          <= next_loop;
      volt_setting_bits    <= battery_target_volts;  // RULE_04
      amp_setting_bits     <= next_amp_bits;         // RULE_12
      adapter_setting_bits <= adapter_limit_amps;    // RULE_13
      sda_out              <= 1'b0;                  // open drain, only ever pulls low
    end
  end

  // ----------------------------------------------------------------
  // switching: duty stepped only at period start to avoid runt pulses; charging off clears it at once
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pwm_cnt <= 8'h00;
      duty    <= 8'h00;
    end else begin
      pwm_cnt <= (pwm_cnt == `CSB_PWM_PERIOD) ? 8'h00 : pwm_cnt + 8'h01;
      duty    <= next_duty;
    end
  end

  // one dead cycle at each end of the on-time keeps the switches apart
  wire hs_on = charge_enable && (pwm_cnt < duty);
  wire ls_on = charge_enable && (pwm_cnt > duty) && (pwm_cnt != `CSB_PWM_PERIOD);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      high_side_gate_drive <= 1'b0;              // RULE_08
      low_side_gate_drive  <= 1'b0;              // RULE_08
    end else begin
      high_side_gate_drive <= hs_on;             // RULE_08
      low_side_gate_drive  <= ls_on;             // RULE_08
    end
  end

endmodule

`default_nettype wire

// >>> csb_bank_bench.sv
// self-checking bench for the setpoint command bank
`timescale 1ns/10ps
`default_nettype none
`include "csb_cfg.svh"

`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module csb_bank_bench;
  import csb_pkg::*;
  // shortened watchdog; long enough to span the adapter table between setpoint writes
  localparam longint unsigned TMO  = 12000;
  localparam logic [6:0]      ADDR = 7'h2a;
  logic        sys_clk, reset, battery_low, battery_below_volts, battery_below_amps, adapter_over_limit;
  logic        scl, host_pull, sda_out, sda_oe, charge_enable, ack;
  logic        high_side_gate_drive, low_side_gate_drive;
  logic [10:0] volt_setting_bits;
  logic [5:0]  amp_setting_bits, adapter_setting_bits;
  csb_loop_t   active_loop;
  wire logic   sda_line;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [15:0] adp [5] = '{16'h0000, 16'h007f, 16'h0080, 16'hffff, 16'h1f00};
  logic [2:0]  lin [3] = '{3'b011, 3'b000, 3'b100};
  csb_loop_t   lex [3] = '{CSB_LOOP_AMPS, CSB_LOOP_VOLTS, CSB_LOOP_ADAPTER};

  // open-drain data wire with pull-up
  assign sda_line = ~(host_pull | sda_oe);

  csb_bank #(.SLAVE_ADDR(ADDR), .TIMEOUT_CYCLES(TMO), .TIMEOUT_W(33)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .battery_low(battery_low), .battery_below_volts(battery_below_volts), .battery_below_amps(battery_below_amps),
    .adapter_over_limit(adapter_over_limit), .volt_setting_bits(volt_setting_bits),
    .amp_setting_bits(amp_setting_bits), .adapter_setting_bits(adapter_setting_bits),
    .charge_enable(charge_enable), .active_loop(active_loop),
    .high_side_gate_drive(high_side_gate_drive), .low_side_gate_drive(low_side_gate_drive));

  csb_smbus_host i_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_pull(host_pull));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      n_errors++;
      stop_test();
    end
  end

  // expected fields worked out from the bit positions of the voltage and adapter command words
  function automatic logic [10:0] vf(input logic [15:0] d);
    return d[14:4];
  endfunction
  function automatic logic [5:0] df(input logic [15:0] d);
    return (d[12:7] == 6'h00) ? 6'h01 : d[12:7];
  endfunction

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_host.write_word(ADDR, c, d, 2, ack);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic expect_state(input logic [10:0] v, input logic [5:0] a, input logic [5:0] d, input logic e);
    `CHK("volt", v, volt_setting_bits)
    `CHK("amps", a, amp_setting_bits)
    `CHK("adapter", d, adapter_setting_bits)
    `CHK("enable", e, charge_enable)
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {reset, battery_low, battery_below_volts, battery_below_amps, adapter_over_limit} = 5'b10000;
    wait_n(5);
    reset = 1'b0;
    wait_n(8);
    expect_state(11'h000, 6'h00, 6'h01, 1'b0);
    `CHK("loop", CSB_LOOP_OFF, active_loop)
    `CHK("gates", 2'b00, {high_side_gate_drive, low_side_gate_drive})
    $display("test reset done");
    wr(`CSB_CMD_VOLTS, 16'h8fff);
    `CHK("ack", 1'b1, ack)
    `CHK("sda out", 1'b0, sda_out)
    expect_state(vf(16'h8fff), 6'h00, 6'h01, 1'b0);
    wr(`CSB_CMD_AMPS, 16'he3ff);
    expect_state(11'h0ff, 6'h07, 6'h01, 1'b1);
    $display("test setpoints done");
    foreach (adp[i]) begin
      wr(`CSB_CMD_ADAPTER, adp[i]);
      `CHK("adapter", df(adp[i]), adapter_setting_bits)
    end
    $display("test adapter done");
    i_host.write_word(7'h2b, `CSB_CMD_VOLTS, 16'h0000, 2, ack);
    `CHK("nack", 1'b0, ack)
    i_host.write_word(ADDR, `CSB_CMD_VOLTS, 16'h0000, 1, ack);
    wr(8'h16, 16'h0000);
    expect_state(11'h0ff, 6'h07, 6'h3e, 1'b1);
    $display("test refused done");
    for (int i = 0; i < 3; i++) begin
      {adapter_over_limit, battery_below_volts, battery_below_amps} = lin[i];
      wait_n(10);
      `CHK("loop", lex[i], active_loop)
    end
    adapter_over_limit = 1'b0;
    battery_low = 1'b1;
    wait_n(8);
    `CHK("foldback", 6'h01, amp_setting_bits)
    battery_low = 1'b0;
    wait_n(8);
    `CHK("restored", 6'h07, amp_setting_bits)
    $display("test loops done");
    wr(`CSB_CMD_VOLTS, 16'h03f0);
    wait_n(4);
    `CHK("low volt", 1'b0, charge_enable)
    `CHK("gates", 2'b00, {high_side_gate_drive, low_side_gate_drive})
    wr(`CSB_CMD_VOLTS, 16'h0400);
    `CHK("min volt", 1'b1, charge_enable)
    wr(`CSB_CMD_AMPS, 16'h0000);
    `CHK("zero amps", 1'b0, charge_enable)
    wr(`CSB_CMD_AMPS, 16'h0380);
    expect_state(11'h040, 6'h07, 6'h3e, 1'b1);
    $display("test limits done");
    wait_n(int'(TMO) + 100);
    `CHK("expired", 1'b0, charge_enable)
    wr(`CSB_CMD_VOLTS, 16'h0400);
    `CHK("one write", 1'b0, charge_enable)
    wr(`CSB_CMD_AMPS, 16'h0380);
    `CHK("rewritten", 1'b1, charge_enable)
    $display("test timeout done");
    reset = 1'b1;
    wait_n(2);
    reset = 1'b0;
    wait_n(8);
    expect_state(11'h000, 6'h00, 6'h01, 1'b0);
    $display("test second reset done");
    stop_test();
  end
endmodule

`default_nettype wire

// >>> csb_bank_checker.sv
// concurrent assertions on the ports of the setpoint command bank
`timescale 1ns/10ps
`default_nettype none

module csb_bank_checker
  import csb_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        battery_low,
  input wire logic        battery_below_volts,
  input wire logic        adapter_over_limit,
  input wire logic [10:0] volt_setting_bits,
  input wire logic [5:0]  amp_setting_bits,
  input wire logic [5:0]  adapter_setting_bits,
  input wire logic        charge_enable,
  input wire csb_loop_t   active_loop,
  input wire logic        high_side_gate_drive,
  input wire logic        low_side_gate_drive
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_reset_values: assert property ($past(reset) |-> volt_setting_bits == 11'h000 &&
    amp_setting_bits == 6'h00 && adapter_setting_bits == 6'h01 && !charge_enable) else $error("bad reset state");
  chk_gates_off: assert property (!charge_enable && !$past(charge_enable) |->
    !high_side_gate_drive && !low_side_gate_drive) else $error("gate drive while charging off");
  chk_loop_off: assert property (!charge_enable && !$past(charge_enable) |->
    active_loop == CSB_LOOP_OFF) else $error("loop active while charging off");
  // the stable guard skips the one edge where a new setpoint and the gate land together
  chk_volt_floor: assert property (charge_enable && $stable(volt_setting_bits) |->
    volt_setting_bits >= 11'h040) else $error("charging below minimum voltage");
  chk_amp_nonzero: assert property (charge_enable && $stable(amp_setting_bits) |->
    amp_setting_bits != 6'h00) else $error("charging with zero current");
  chk_adapter_floor: assert property (adapter_setting_bits != 6'h00) else $error("adapter limit zero");
  chk_foldback_amps: assert property (battery_low [*5] |-> amp_setting_bits == 6'h01)
    else $error("no foldback on low battery");
  chk_adapter_loop: assert property ((charge_enable && adapter_over_limit) [*5] |->
    active_loop == CSB_LOOP_ADAPTER) else $error("adapter loop not in control");
  chk_amp_loop: assert property ((charge_enable && !adapter_over_limit && battery_below_volts) [*5] |->
    active_loop == CSB_LOOP_AMPS) else $error("current loop not in control");
  chk_volt_loop: assert property ((charge_enable && !adapter_over_limit && !battery_below_volts) [*5] |->
    active_loop == CSB_LOOP_VOLTS) else $error("voltage loop not in control");
  chk_gates_apart: assert property (!(high_side_gate_drive && low_side_gate_drive))
    else $error("both gate drives on at once");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  cov_adapter: cover property (active_loop == CSB_LOOP_ADAPTER);
  cov_stop: cover property ($fell(charge_enable));
  cov_fold: cover property (charge_enable && battery_low);
endmodule

bind csb_bank csb_bank_checker i_chk (
  .sys_clk(sys_clk), .reset(reset), .battery_low(battery_low), .battery_below_volts(battery_below_volts),
  .adapter_over_limit(adapter_over_limit), .volt_setting_bits(volt_setting_bits),
  .amp_setting_bits(amp_setting_bits), .adapter_setting_bits(adapter_setting_bits),
  .charge_enable(charge_enable), .active_loop(active_loop),
  .high_side_gate_drive(high_side_gate_drive), .low_side_gate_drive(low_side_gate_drive)
);

`default_nettype wire

// >>> csb_cfg.svh
// setpoint command bank: offsets, field positions, reset values and timing counts
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH

// ----------------------------------------------------------------
// command codes (register offsets)
// ----------------------------------------------------------------
`define CSB_CMD_AMPS        8'h14
`define CSB_CMD_VOLTS       8'h15
`define CSB_CMD_ADAPTER     8'h3f

// ----------------------------------------------------------------
// field positions inside the 16-bit data word
// ----------------------------------------------------------------
`define CSB_VOLT_LSB        4
`define CSB_VOLT_MSB        14
`define CSB_AMP_LSB         7
`define CSB_AMP_MSB         12
`define CSB_ADP_LSB         7
`define CSB_ADP_MSB         12

// ----------------------------------------------------------------
// reset values and thresholds, in field steps
// ----------------------------------------------------------------
`define CSB_VOLT_RESET      11'h000
`define CSB_AMP_RESET       6'h00
`define CSB_ADP_RESET       6'h01
`define CSB_ADP_MIN         6'h01
`define CSB_AMP_FOLDBACK    6'h01
`define CSB_VOLT_MIN_CODE   11'h040

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CSB_CLK_HZ          64'd25000000
`define CSB_TIMEOUT_S       64'd175
`define CSB_TIMEOUT_CYCLES  (`CSB_TIMEOUT_S * `CSB_CLK_HZ)
`define CSB_PWM_PERIOD      8'hff

`endif

// >>> csb_pkg.sv
// setpoint command bank: shared types
package csb_pkg;

  // regulation loop in control
  typedef enum logic [1:0] {
    CSB_LOOP_OFF     = 2'b00,
    CSB_LOOP_AMPS    = 2'b01,
    CSB_LOOP_VOLTS   = 2'b10,
    CSB_LOOP_ADAPTER = 2'b11
  } csb_loop_t;

  // serial receiver byte position
  typedef enum logic [2:0] {
    CSB_RX_IDLE   = 3'b000,
    CSB_RX_ADDR   = 3'b001,
    CSB_RX_CMD    = 3'b010,
    CSB_RX_DLO    = 3'b011,
    CSB_RX_DHI    = 3'b100,
    CSB_RX_IGNORE = 3'b101
  } csb_rx_state_t;

endpackage

// >>> csb_smbus_host.sv
// smbus host model: drives write-word frames onto the driven clock wire and the open-drain data wire
`timescale 1ns/10ps
`default_nettype none

module csb_smbus_host (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  // clock is driven high between frames with the data wire released to the pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // one bus phase; six cycles keeps every phase above the receiver's four-cycle minimum
  task automatic ph();
    repeat (6) @(negedge sys_clk);
  endtask

  // data moves only while the clock is low, or the receiver would see a false start or stop
  task automatic bit_out(input logic b, output logic seen);
    scl = 1'b0;
    ph();
    sda_pull = ~b;
    ph();
    scl = 1'b1;
    ph();
    seen = sda_line;
  endtask

  // eight bits msb first, then the wire is released for the ack bit
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i], s);
    end
    bit_out(1'b1, s);
    ack = ~s;
  endtask

  // start, address with write bit, command, low byte, high byte, stop; nb cuts the data short
  task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] data,
                            input int nb, output logic ack);
    logic a;
    sda_pull = 1'b1;
    ph();
    byte_out({addr, 1'b0}, ack);
    byte_out(cmd, a);
    if (nb > 0) begin
      byte_out(data[7:0], a);
    end
    if (nb > 1) begin
      byte_out(data[15:8], a);
    end
    scl = 1'b0;
    ph();
    sda_pull = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_pull = 1'b0;
    ph();
  endtask
endmodule

`default_nettype wire

// >>> csb_smbus_rx.sv
// setpoint command bank: write-word receiver on the two-wire serial bus
`timescale 1ns/10ps
`default_nettype none

module csb_smbus_rx
  import csb_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a  // arbitrary value
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_oe,
  csb_wr_if.rx      wr
);

  logic [2:0]    scl_sync;
  logic [2:0]    sda_sync;
  csb_rx_state_t state;
  logic [3:0]    bit_cnt;
  logic [7:0]    shift;
  logic          ack_pend;

  // ----------------------------------------------------------------
  // pin synchronisers; edges are judged on stages two and three only
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  wire       scl_rise = scl_sync[1] & ~scl_sync[2];
  wire       scl_fall = ~scl_sync[1] & scl_sync[2];
  wire       start    = scl_sync[2] & scl_sync[1] & ~sda_sync[1] & sda_sync[2];
  wire       stop     = scl_sync[2] & scl_sync[1] & sda_sync[1] & ~sda_sync[2];
  wire [7:0] rx_byte  = {shift[6:0], sda_sync[2]};
  wire       byte_end = scl_rise && (bit_cnt == 4'h7);
  wire       ack_clk  = scl_rise && (bit_cnt == 4'h8);
  wire       addr_hit = (rx_byte[7:1] == SLAVE_ADDR) && !rx_byte[0];

  // ----------------------------------------------------------------
  // byte walk: address, command, data low, data high
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || stop) begin
      state    <= CSB_RX_IDLE;
      bit_cnt  <= 4'h0;
      ack_pend <= 1'b0;
    end else if (start) begin
      state    <= CSB_RX_ADDR;
      bit_cnt  <= 4'h0;
      ack_pend <= 1'b0;
    end else if (byte_end && state != CSB_RX_IDLE) begin
      bit_cnt <= 4'h8;
      case (state)
        CSB_RX_ADDR: begin
          state    <= addr_hit ? CSB_RX_CMD : CSB_RX_IGNORE;
          ack_pend <= addr_hit;
        end
        CSB_RX_CMD: begin
          state    <= CSB_RX_DLO;
          ack_pend <= 1'b1;
        end
        CSB_RX_DLO: begin
          state    <= CSB_RX_DHI;
          ack_pend <= 1'b1;
        end
        CSB_RX_DHI: begin
          state    <= CSB_RX_IGNORE;
          ack_pend <= 1'b1;
        end
        default: ack_pend <= 1'b0;  // extra bytes and reads get no ack
      endcase
    end else if (scl_rise) begin
      bit_cnt <= ack_clk ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // shift register and captured command and data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shift     <= 8'h00;
      wr.cmd    <= 8'h00;
      wr.data   <= 16'h0000;
      wr.wr_stb <= 1'b0;
    end else begin
      wr.wr_stb <= byte_end && (state == CSB_RX_DHI);
      if (scl_rise && bit_cnt < 4'h8)
        shift <= rx_byte;
      if (byte_end && state == CSB_RX_CMD)
        wr.cmd <= rx_byte;
      if (byte_end && state == CSB_RX_DLO)
        wr.data[7:0] <= rx_byte;
      if (byte_end && state == CSB_RX_DHI)
        wr.data[15:8] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // ack drive: pull data low from the fall after bit 8 to the next fall
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || stop || start)
      sda_oe <= 1'b0;
    else if (scl_fall)
      sda_oe <= ack_pend && (bit_cnt == 4'h8) && !sda_oe;
  end

endmodule

`default_nettype wire

// >>> csb_timeout.sv
// setpoint command bank: watchdog on setpoint writes
`timescale 1ns/10ps
`default_nettype none
`include "csb_cfg.svh"

module csb_timeout
  import csb_pkg::*;
#(
  parameter int               TW     = 33,
  parameter longint unsigned  CYCLES = `CSB_TIMEOUT_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic kick,
  output logic      expired
);

  logic [TW-1:0] count;
  wire  [TW-1:0] last_count = TW'(CYCLES - 64'd1);
  wire           at_end     = (count == last_count);

  // ----------------------------------------------------------------
  // free counter restarted by every kick; one pulse at the end
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || kick) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= at_end ? '0 : count + TW'(1);
      expired <= at_end;
    end
  end

endmodule

`default_nettype wire

// >>> csb_wr_if.sv
// setpoint command bank: write-word event carried from receiver to core
`timescale 1ns/10ps
`default_nettype none

interface csb_wr_if;
  logic        wr_stb;
  logic [7:0]  cmd;
  logic [15:0] data;

  modport rx (output wr_stb, output cmd, output data);
  modport core (input wr_stb, input cmd, input data);
endinterface

`default_nettype wire
